// File: core/fpp_regs.svh
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH
// Register byte offsets
`define FPP_OFS_KEY 8'h00
`define FPP_OFS_VIEW 8'h04
`define FPP_OFS_STATUS 8'h08
`define FPP_OFS_PRE1 8'h10
`define FPP_OFS_PRE2 8'h14
`define FPP_OFS_BPRE 8'h18
`define FPP_OFS_SCALE 8'h1c
`define FPP_OFS_TO1 8'h20
`define FPP_OFS_TO2 8'h24
`define FPP_OFS_TO3 8'h28
`define FPP_OFS_MODE 8'h2c
`define FPP_OFS_TEST 8'h30
// Key codes written to the key register
`define FPP_KEY_BTN1 4'h1
`define FPP_KEY_BTN2 4'h2
`define FPP_KEY_BTN3 4'h3
`define FPP_KEY_BTN4 4'h4
`define FPP_KEY_BTN5 4'h5
`define FPP_KEY_BTN6 4'h6
`define FPP_KEY_INC 4'ha
`define FPP_KEY_ENTER 4'he
`define FPP_KEY_EXIT 4'hf
// Function codes
`define FPP_CODE_TO1 8'h53
`define FPP_CODE_TO2 8'h55
`define FPP_CODE_TO3 8'h65
`define FPP_CODE_MIN 8'h41
`define FPP_CODE_MAX 8'h66
// Limits, BCD digits
`define FPP_TO_MAX 20'h59999
`define FPP_SF_MIN 20'h00001
`define FPP_SF_MAX 20'h59999
// Reset values
`define FPP_SF_RST 20'h10000
// Timing
`define FPP_CLK_HZ 10000000
`define FPP_STEP_MS 500
`define FPP_EXIT_S 6
`endif

// File: core/fpp_pkg.sv
package fpp_pkg;
  typedef enum logic [2:0] {
    FPP_IDLE, FPP_SEL, FPP_MODE_ID, FPP_DATA, FPP_TEST_ARM, FPP_TEST_RUN,
    FPP_TEST_OUT
  } fpp_state_e;
  typedef enum logic [2:0] {
    FPP_T_NONE, FPP_T_PRE1, FPP_T_PRE2, FPP_T_BPRE, FPP_T_SCALE,
    FPP_T_TO1, FPP_T_TO2, FPP_T_TO3
  } fpp_target_e;
  typedef logic [19:0] fpp_bcd_t;
endpackage : fpp_pkg

// File: core/fpp_store.sv
`timescale 1ns/10ps
// One committed value; load only on enter
module fpp_store #(
  parameter logic [19:0] RST_VAL = 20'h00000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load
  input wire logic load,
  input wire logic [19:0] din,
  output logic [19:0] dout
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= RST_VAL;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule : fpp_store

// File: core/fpp_panel.sv
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "fpp_regs.svh"
module fpp_panel import fpp_pkg::*; #(
  parameter int STEP_CYC = `FPP_CLK_HZ / 1000 * `FPP_STEP_MS,
  parameter int EXIT_CYC = `FPP_CLK_HZ * `FPP_EXIT_S
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Counter core side
  input wire logic program_lockout_input,
  input wire logic [19:0] raw_count,
  input wire logic batch_view,
  output logic [35:0] scaled_count,
  output logic [19:0] display_digits,
  output logic [4:0] display_points,
  output logic test_active,
  output logic test_out1,
  output logic test_out2
);
  //////////////////////////////////////////////////////////////////////////
  fpp_state_e state;
  fpp_target_e target;
  fpp_bcd_t edit;
  logic [7:0] code;
  logic [3:0] mode_digit;
  logic [7:0] mode_mem [0:31];
  logic [4:0] mode_slot;
  logic [3:0] test_digit;
  logic [31:0] tmr;
  logic key_wr;
  logic [3:0] key;
  logic commit;
  logic [19:0] pre1, pre2, bpre, scale, to1, to2, to3;
  logic [19:0] cur_val;
  logic edit_ok;
  logic code_ok;

  assign key_wr = wr && addr == `FPP_OFS_KEY;
  assign key = wdata[3:0];
  // Lockout blocks stores and the output test; navigation and viewing go on
  assign commit = key_wr && key == `FPP_KEY_ENTER && state == FPP_DATA
                  && !program_lockout_input && edit_ok;
  // Legal codes: 41..66 with a valid low digit 1..6
  assign code_ok = code >= `FPP_CODE_MIN && code <= `FPP_CODE_MAX
                   && code[3:0] >= 4'h1 && code[3:0] <= 4'h6;
  // Tens 4..6 and units 1..6 give every legal code a slot of its own
  assign mode_slot = {code[5:4], code[2:0]};

  always_comb begin
    unique case (target)
      FPP_T_PRE1: cur_val = pre1;
      FPP_T_PRE2: cur_val = pre2;
      FPP_T_BPRE: cur_val = bpre;
      FPP_T_SCALE: cur_val = scale;
      FPP_T_TO1: cur_val = to1;
      FPP_T_TO2: cur_val = to2;
      FPP_T_TO3: cur_val = to3;
      default: cur_val = 20'h00000;
    endcase
  end

  always_comb begin
    if (target == FPP_T_SCALE) begin
      edit_ok = edit >= `FPP_SF_MIN && edit <= `FPP_SF_MAX;
    end else if (target == FPP_T_TO1 || target == FPP_T_TO2
                 || target == FPP_T_TO3) begin
      edit_ok = edit <= `FPP_TO_MAX;
    end else begin
      edit_ok = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Value stores, loaded only by enter
  fpp_store u_pre1 (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_PRE1), .din(edit), .dout(pre1));
  fpp_store u_pre2 (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_PRE2), .din(edit), .dout(pre2));
  fpp_store u_bpre (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_BPRE), .din(edit), .dout(bpre));
  fpp_store #(.RST_VAL(`FPP_SF_RST)) u_scale (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_SCALE), .din(edit), .dout(scale));
  fpp_store u_to1 (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_TO1), .din(edit), .dout(to1));
  fpp_store u_to2 (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_TO2), .din(edit), .dout(to2));
  fpp_store u_to3 (.clk(clk), .rst(rst),
    .load(commit && target == FPP_T_TO3), .din(edit), .dout(to3));

  //////////////////////////////////////////////////////////////////////////
  // Key interpreter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= FPP_IDLE;
      target <= FPP_T_NONE;
      edit <= 20'h00000;
      code <= 8'h00;
      mode_digit <= 4'h0;
    end else if (state == FPP_TEST_RUN && tmr == 32'(STEP_CYC - 1)
                 && test_digit == 4'h0) begin
      state <= FPP_TEST_OUT;
    end else if (state == FPP_TEST_OUT && tmr == 32'(EXIT_CYC - 1)) begin
      state <= FPP_IDLE;
    end else if (key_wr && key == `FPP_KEY_EXIT) begin
      state <= FPP_IDLE; // Edit buffer dropped
      target <= FPP_T_NONE;
    end else if (key_wr) begin
      unique case (state)
        FPP_IDLE: begin
          if (key == `FPP_KEY_BTN4) begin
            state <= FPP_SEL;
            code <= 8'h00;
          end else if (key == `FPP_KEY_BTN6) begin
            state <= FPP_TEST_ARM;
          end else if (key == `FPP_KEY_BTN3) begin
            state <= FPP_DATA;
            target <= FPP_T_SCALE;
            edit <= scale;
          end else if (key == `FPP_KEY_BTN1) begin
            state <= FPP_DATA;
            target <= batch_view ? FPP_T_BPRE : FPP_T_PRE1;
            edit <= batch_view ? bpre : pre1;
          end else if (key == `FPP_KEY_BTN2 && !batch_view) begin
            state <= FPP_DATA;
            target <= FPP_T_PRE2;
            edit <= pre2;
          end
        end
        FPP_SEL: begin
          if (key <= 4'h9) begin
            code <= {code[3:0], key}; // Two digits, shown left
          end else if (key == `FPP_KEY_ENTER) begin
            if (code == `FPP_CODE_TO1 || code == `FPP_CODE_TO2
                || code == `FPP_CODE_TO3) begin
              state <= FPP_DATA;
              target <= code == `FPP_CODE_TO1 ? FPP_T_TO1 :
                        code == `FPP_CODE_TO2 ? FPP_T_TO2 : FPP_T_TO3;
              edit <= code == `FPP_CODE_TO1 ? to1 :
                      code == `FPP_CODE_TO2 ? to2 : to3;
            end else if (code_ok) begin
              state <= FPP_MODE_ID;
              mode_digit <= mode_mem[mode_slot][3:0];
            end else begin
              state <= FPP_IDLE;
            end
          end
        end
        FPP_MODE_ID: begin
          if (key <= 4'h9) begin
            mode_digit <= key; // Shown right
          end else if (key == `FPP_KEY_ENTER) begin
            state <= FPP_IDLE;
          end
        end
        FPP_DATA: begin
          if (key >= `FPP_KEY_BTN1 && key <= `FPP_KEY_BTN5) begin
            // Button under a digit bumps it, wrapping 9 to 0
            for (int i = 0; i < 5; i++) begin
              if (key == 4'(5 - i)) begin
                edit[i*4 +: 4] <= edit[i*4 +: 4] == 4'h9 ? 4'h0 :
                                  edit[i*4 +: 4] + 4'h1;
              end
            end
          end else if (key == `FPP_KEY_ENTER) begin
            state <= FPP_IDLE;
            target <= FPP_T_NONE;
          end
        end
        FPP_TEST_ARM: begin
          state <= key == `FPP_KEY_INC ? FPP_TEST_RUN : FPP_IDLE;
        end
        default: begin
        end
      endcase
    end
  end

  // Mode store, one slot per code; locked out under lockout
  always_ff @(posedge clk) begin
    if (key_wr && key == `FPP_KEY_ENTER && state == FPP_MODE_ID
        && !program_lockout_input) begin
      mode_mem[mode_slot] <= {4'h0, mode_digit};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Self test sequencer; counting inputs untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr <= 32'h0;
      test_digit <= 4'hf;
    end else if (state == FPP_TEST_RUN || state == FPP_TEST_OUT) begin
      if ((state == FPP_TEST_RUN && tmr == 32'(STEP_CYC - 1))) begin
        tmr <= 32'h0;
        test_digit <= test_digit == 4'hf ? 4'h9 : test_digit - 4'h1;
      end else if (state == FPP_TEST_OUT && tmr == 32'(EXIT_CYC - 1)) begin
        tmr <= 32'h0;
      end else begin
        tmr <= tmr + 32'h1;
      end
    end else begin
      tmr <= 32'h0;
      test_digit <= 4'hf;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_out1 <= 1'b0;
      test_out2 <= 1'b0;
    end else if (state != FPP_TEST_OUT || program_lockout_input) begin
      test_out1 <= 1'b0;
      test_out2 <= 1'b0;
    end else if (key_wr && key == `FPP_KEY_BTN1) begin
      test_out1 <= ~test_out1;
    end else if (key_wr && key == `FPP_KEY_BTN2) begin
      test_out2 <= ~test_out2;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Display and scaled readout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display_digits <= 20'h00000;
      display_points <= 5'h00;
      test_active <= 1'b0;
      scaled_count <= 36'h0;
    end else begin
      // Binary product; decoding to BCD left to the display path
      scaled_count <= 36'(raw_count * scale);
      test_active <= state == FPP_TEST_RUN || state == FPP_TEST_OUT;
      display_points <= state == FPP_TEST_RUN && test_digit == 4'hf ?
                        5'h1f : 5'h00;
      unique case (state)
        FPP_SEL: display_digits <= {code, 12'h000};
        FPP_MODE_ID: display_digits <= {code, 8'h00, mode_digit};
        FPP_DATA: display_digits <= edit;
        FPP_TEST_RUN: display_digits <= {5{test_digit}};
        default: display_digits <= raw_count;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads: viewing never changes state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `FPP_OFS_VIEW: rdata <= {12'h000, display_digits};
        `FPP_OFS_STATUS: rdata <= {25'h0, program_lockout_input,
                                   test_active, 2'b00, state};
        `FPP_OFS_PRE1: rdata <= {12'h000, pre1};
        `FPP_OFS_PRE2: rdata <= {12'h000, pre2};
        `FPP_OFS_BPRE: rdata <= {12'h000, bpre};
        `FPP_OFS_SCALE: rdata <= {12'h000, scale};
        `FPP_OFS_TO1: rdata <= {12'h000, to1};
        `FPP_OFS_TO2: rdata <= {12'h000, to2};
        `FPP_OFS_TO3: rdata <= {12'h000, to3};
        `FPP_OFS_MODE: rdata <= {24'h0, code};
        `FPP_OFS_TEST: rdata <= {30'h0, test_out2, test_out1};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_lock_store: assert property (@(posedge clk) disable iff (rst)
    program_lockout_input |=> $stable(scale) && $stable(pre1))
    else $error("store changed under lockout");
  a_sf_range: assert property (@(posedge clk) disable iff (rst)
    commit && target == FPP_T_SCALE |=> scale >= 20'h00001
    && scale <= 20'h59999) else $error("scale factor out of range");
  a_to_range: assert property (@(posedge clk) disable iff (rst)
    to1 <= 20'h59999 && to2 <= 20'h59999 && to3 <= 20'h59999)
    else $error("timed output above limit");
  a_enter_only: assert property (@(posedge clk) disable iff (rst)
    !(key_wr && key == `FPP_KEY_ENTER) |=> $stable(to1) && $stable(pre2))
    else $error("value stored without enter");
  a_out_lock: assert property (@(posedge clk) disable iff (rst)
    program_lockout_input |=> !test_out1 && !test_out2)
    else $error("output test under lockout");
  a_out_mode: assert property (@(posedge clk) disable iff (rst)
    test_out1 |-> $past(state) == FPP_TEST_OUT)
    else $error("output test outside test mode");
  a_scale_mul: assert property (@(posedge clk) disable iff (rst)
    ##1 scaled_count == 36'($past(raw_count) * $past(scale)))
    else $error("scaled readout wrong");
  a_test_start: assert property (@(posedge clk) disable iff (rst)
    state == FPP_TEST_ARM && key_wr && key == `FPP_KEY_INC
    |=> state == FPP_TEST_RUN ##1 display_points == 5'h1f)
    else $error("self test did not start");
  a_bad_code: assert property (@(posedge clk) disable iff (rst)
    state == FPP_SEL && key_wr && key == `FPP_KEY_ENTER && !code_ok
    && code != 8'h53 && code != 8'h55 && code != 8'h65
    |=> state == FPP_IDLE) else $error("illegal code accepted");
endmodule : fpp_panel

// File: verification/fpp_core_model.sv
`timescale 1ns/10ps
module fpp_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count feed
  output logic [19:0] raw_count
);
  // Never pauses, so any panel work that stalls counting shows up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_count <= 20'h00000;
    end else begin
      raw_count <= raw_count + 20'h00007;
    end
  end
endmodule : fpp_core_model

// File: verification/front_panel_programming_bench.sv
`timescale 1ns/10ps
`include "fpp_regs.svh"
module front_panel_programming_bench;
  localparam int STEP = 4;
  localparam int EXIT = 20;
  logic clk, rst, wr, rd, lock, batch_view;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [19:0] raw_count, display_digits;
  logic [35:0] scaled_count;
  logic [4:0] display_points;
  logic test_active, test_out1, test_out2;
  int fail_count, tests_run, cyc, n, d;
  logic [7:0] codes [3];
  //////////////////////////////////////////////////////////////////////////
  fpp_core_model core (.clk(clk), .rst(rst), .raw_count(raw_count));
  fpp_panel #(.STEP_CYC(STEP), .EXIT_CYC(EXIT)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .program_lockout_input(lock), .raw_count(raw_count),
    .batch_view(batch_view), .scaled_count(scaled_count),
    .display_digits(display_digits), .display_points(display_points),
    .test_active(test_active), .test_out1(test_out1),
    .test_out2(test_out2));
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [35:0] got, input logic [35:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Leaves one idle cycle so wr is never raised at the edge it drops
  task key(input logic [3:0] k);
    @(posedge clk);
    wr <= 1'b1;
    addr <= `FPP_OFS_KEY;
    wdata <= {28'h0000000, k};
    @(posedge clk);
    wr <= 1'b0;
  endtask : key
  task expect_reg(input logic [7:0] a, input logic [19:0] e, input string m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk({4'h0, v}, {16'h0000, e}, m);
  endtask : expect_reg
  task edit(input logic [3:0] open, btn, input int cnt, input logic [3:0] cl);
    key(open);
    repeat (cnt) key(btn);
    key(cl);
  endtask : edit
  task open_code(input logic [7:0] c);
    key(`FPP_KEY_BTN4);
    key(c[7:4]);
    key(c[3:0]);
    key(`FPP_KEY_ENTER);
  endtask : open_code
  task chk_scaled(input logic [19:0] s);
    logic [19:0] r;
    @(posedge clk);
    #1 r = raw_count;
    @(posedge clk);
    #1 chk(scaled_count, {16'h0000, r} * {16'h0000, s}, "scaled");
  endtask : chk_scaled
  task test_end(input string m);
    $display("test done: %s", m);
  endtask : test_end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole sequence needs about 340 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      wrap_up();
    end
  end
  initial begin
    {wr, rd, lock, batch_view, addr, wdata} = '0;
    rst = 1'b1;
    codes = '{`FPP_CODE_TO1, `FPP_CODE_TO2, `FPP_CODE_TO3};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    expect_reg(`FPP_OFS_SCALE, `FPP_SF_RST, "scale reset");
    chk_scaled(`FPP_SF_RST);
    test_end("reset");
    edit(`FPP_KEY_BTN3, `FPP_KEY_BTN5, 1, `FPP_KEY_ENTER);
    expect_reg(`FPP_OFS_SCALE, 20'h10001, "scale commit");
    chk_scaled(20'h10001);
    edit(`FPP_KEY_BTN3, `FPP_KEY_BTN1, 5, `FPP_KEY_ENTER);
    expect_reg(`FPP_OFS_SCALE, 20'h10001, "scale range");
    test_end("scale");
    key(`FPP_KEY_BTN3);
    @(posedge clk);
    #1 chk(display_digits, 36'h10001, "old value shown");
    key(`FPP_KEY_BTN4);
    expect_reg(`FPP_OFS_VIEW, 20'h10011, "digit bump");
    key(`FPP_KEY_EXIT);
    expect_reg(`FPP_OFS_SCALE, 20'h10001, "exit keeps");
    test_end("entry");
    lock <= 1'b1;
    edit(`FPP_KEY_BTN3, `FPP_KEY_BTN5, 1, `FPP_KEY_ENTER);
    expect_reg(`FPP_OFS_SCALE, 20'h10001, "locked store");
    expect_reg(`FPP_OFS_PRE1, 20'h00000, "locked view");
    lock <= 1'b0;
    test_end("lockout");
    edit(`FPP_KEY_BTN1, `FPP_KEY_BTN5, 2, `FPP_KEY_ENTER);
    edit(`FPP_KEY_BTN2, `FPP_KEY_BTN5, 1, `FPP_KEY_ENTER);
    batch_view <= 1'b1;
    edit(`FPP_KEY_BTN1, `FPP_KEY_BTN5, 3, `FPP_KEY_ENTER);
    batch_view <= 1'b0;
    expect_reg(`FPP_OFS_PRE1, 20'h00002, "preset one");
    expect_reg(`FPP_OFS_PRE2, 20'h00001, "preset two");
    expect_reg(`FPP_OFS_BPRE, 20'h00003, "batch preset");
    test_end("presets");
    for (int i = 0; i < 3; i++) begin
      open_code(codes[i]);
      key(`FPP_KEY_BTN5);
      key(`FPP_KEY_ENTER);
      expect_reg(8'h20 + 8'(4 * i), 20'h00001, "timed out");
      open_code(codes[i]);
      repeat (6) key(`FPP_KEY_BTN1);
      key(`FPP_KEY_ENTER);
      expect_reg(8'h20 + 8'(4 * i), 20'h00001, "timed range");
    end
    test_end("timed outputs");
    open_code(8'h99);
    expect_reg(`FPP_OFS_STATUS, 20'h00000, "illegal code");
    open_code(8'h46);
    expect_reg(`FPP_OFS_STATUS, 20'h00002, "mode id open");
    key(`FPP_KEY_BTN3);
    key(`FPP_KEY_ENTER);
    expect_reg(`FPP_OFS_STATUS, 20'h00000, "mode stored");
    open_code(8'h52);
    key(4'h7);
    key(`FPP_KEY_ENTER);
    open_code(8'h46);
    expect_reg(`FPP_OFS_VIEW, 20'h46003, "mode kept");
    expect_reg(`FPP_OFS_MODE, 20'h00046, "code view");
    key(`FPP_KEY_EXIT);
    test_end("codes");
    key(`FPP_KEY_BTN6);
    key(`FPP_KEY_INC);
    @(posedge clk);
    #1 chk(display_points, 36'h1f, "points lit");
    chk(test_active, 36'h1, "test on");
    for (d = 9; d >= 0; d--) begin
      n = 0;
      while (display_digits !== {5{d[3:0]}} && n < 30) begin
        @(posedge clk);
        #1 n++;
      end
      chk(display_digits, {16'h0000, {5{d[3:0]}}}, "descend");
    end
    chk_scaled(20'h10001);
    repeat (STEP) @(posedge clk);
    key(`FPP_KEY_BTN1);
    #1 chk(test_out1, 36'h1, "out test");
    lock <= 1'b1;
    key(`FPP_KEY_BTN2);
    #1 chk(test_out2, 36'h0, "out inhibited");
    chk(test_out1, 36'h0, "out1 inhibited");
    chk(test_active, 36'h1, "still testing");
    lock <= 1'b0;
    repeat (EXIT + 4) @(posedge clk);
    #1 chk(test_active, 36'h0, "auto exit");
    test_end("self test");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    expect_reg(`FPP_OFS_SCALE, `FPP_SF_RST, "mid-run reset");
    expect_reg(`FPP_OFS_TO1, 20'h00000, "reset clears");
    test_end("reset again");
    wrap_up();
  end
endmodule : front_panel_programming_bench
